// [wr_scan_consts.svh]
`ifndef WR_SCAN_CONSTS_SVH
`define WR_SCAN_CONSTS_SVH
`define CTRL_OFS 8'h00
`define WORD_OFS 8'h04
`define OFFSET_OFS 8'h08
`define RESULT_OFS 8'h0C
`define STATUS_OFS 8'h10
`define CTRL_AUTO_BIT 0
`define CTRL_ZS_BIT 1
`define CTRL_RST 2'h0
`define WORD_RST 13'h0000
`define OFFSET_RST 15'h0000
`define WORD_GAIN_LSB 9
`define RESULT_VALID_BIT 16
`define GAIN_MAX 4'hB
`define CLK_NS 40
`define CONV_MAX_NS 15000
`define SETTLE_NS 2000
`define SAMPLE_NS 1000
`define STD_PERIOD_NS 50000
`define ZS_PERIOD_NS 100000
`define AUTO_PERIOD_NS 166667
`define SER_DIV 4
`endif

// [wr_scan_pkg.sv]
package wr_scan_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETTLE = 4'b0010,
    S_WAIT = 4'b0100,
    S_SAMPLE = 4'b1000
  } seq_state_type;
  typedef logic [3:0] gain_type;
  typedef logic [11:0] sample_type;
endpackage

// [sar_engine.sv]
`timescale 1ns/10ps
module sar_engine #(
  parameter int WIDTH = 12,
  parameter int BIT_CYC = 28
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic cmp_i,
  output logic [WIDTH-1:0] dac_o,
  output logic busy_o,
  output logic done_o,
  output logic [WIDTH-1:0] result_o
);
  logic [WIDTH-1:0] mask;
  logic [7:0] tick_cnt;
  wire bit_end = busy_o && (tick_cnt == 8'(BIT_CYC - 1));
  // cmp_i high: held sample at or above the trial level, keep the bit
  wire [WIDTH-1:0] kept = cmp_i ? dac_o : (dac_o & ~mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_o <= '0;
      mask <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= '0;
      tick_cnt <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        mask <= {1'b1, {(WIDTH-1){1'b0}}};
        dac_o <= {1'b1, {(WIDTH-1){1'b0}}};
        busy_o <= 1'b1;
        tick_cnt <= 8'h00;
      end else if (busy_o) begin
        tick_cnt <= bit_end ? 8'h00 : tick_cnt + 8'h01;
        if (bit_end) begin
          mask <= mask >> 1;
          dac_o <= kept | (mask >> 1);
          if (mask[0]) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            // offset binary to two's complement: flip the sign bit
            result_o <= {~kept[WIDTH-1], kept[WIDTH-2:0]};
          end
        end
      end
    end
  end
endmodule

// [wide_range_scan_sequencer.sv]
// Overview of operation
// - each address-gain word written to a populated group is captured in a holding register.
// - captured word is decoded to close the channel gate and set gain.
// - first switching level picks one input of eight on a module.
// - second switching level enables exactly one module of sixteen.
// - gain is one of twelve binary steps, unity up to 2048.
// - gain comes from the word, or is chosen by automatic ranging.
// - automatic ranging settles on the highest gain without overflow; the code stops at the first gain reaching 3/8 of full scale, or at 2048.
// - automatic ranging steps gain using the amplifier comparator.
// - conversion gives eleven magnitude bits plus sign within 15 us.
// - result is sent out serially in two's complement form.
// - each cycle runs selection, then sampling, then digitizing.
// - next channel may be selected while the held sample converts.
// - results are double buffered, readable most of each period.
// - cycle rate is 20 kHz, 10 kHz zero suppressed, 6 kHz autorange.
// - zero suppression takes a 15-bit signed offset word.
// - addressing covers 512 inputs, populated in groups of eight.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "wr_scan_consts.svh"
module wide_range_scan_sequencer #(
  parameter int POP_GROUPS = 64,
  parameter int STD_PERIOD = (`STD_PERIOD_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int ZS_PERIOD = (`ZS_PERIOD_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int AUTO_PERIOD = (`AUTO_PERIOD_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SER_DIV = `SER_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmp_i,
  input wire logic below_range_i,
  output logic [7:0] chan_gate_o,
  output logic [15:0] module_en_o,
  output logic [3:0] unit_en_o,
  output wr_scan_pkg::gain_type gain_o,
  output logic sample_o,
  output wr_scan_pkg::sample_type dac_o,
  output logic [14:0] offset_dac_o,
  output logic ser_data_o,
  output logic ser_clk_o,
  output logic ser_frame_o
);
  import wr_scan_pkg::*;

  localparam int SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int SAMPLE_CYC = (`SAMPLE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int CONV_CYC = `CONV_MAX_NS / `CLK_NS;
  localparam int BIT_CYC = CONV_CYC / 13;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [15:0] onehot(input logic [3:0] n);
    return 16'h0001 << n;
  endfunction

  seq_state_type state, next_state;
  logic auto_en, zs_en, pending, bad_addr, overrun;
  logic [12:0] word;
  logic [14:0] offset;
  logic [12:0] tmr, period_cnt;
  logic cmp_m, cmp_s, below_m, below_s;
  logic conv_start, conv_busy, conv_done;
  sample_type conv_data, s2_data, res_data;
  gain_type cv_gain, s2_gain, res_gain;
  logic s2_full, valid;
  logic [15:0] sh;
  logic [4:0] sh_cnt;
  logic [7:0] div_cnt;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire hit_ctrl = wb_adr_i == `CTRL_OFS;
  wire hit_word = wb_adr_i == `WORD_OFS;
  wire hit_off = wb_adr_i == `OFFSET_OFS;
  wire hit_res = wb_adr_i == `RESULT_OFS;
  wire hit_stat = wb_adr_i == `STATUS_OFS;
  wire [31:0] ctrl_rd = {30'h0, zs_en, auto_en};
  wire [31:0] m_ctrl = merge(ctrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0] m_word = merge({19'h0, word}, wb_dat_i, wb_sel_i);
  wire [31:0] m_off = merge({17'h0, offset}, wb_dat_i, wb_sel_i);
  wire word_ok = int'(m_word[8:3]) < POP_GROUPS;
  wire wr_word = wr & hit_word;
  wire rd_res = rd & hit_res;
  wire rd_stat = rd & hit_stat;
  wire seq_busy = state != S_IDLE;
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_word ? {19'h0, word} :
    hit_off ? {17'h0, offset} :
    hit_res ? {15'h0, valid, res_gain, res_data} :
    hit_stat ? {27'h0, overrun, bad_addr, pending, conv_busy, seq_busy} :
    32'h0000_0000;

  // word decode
  wire [3:0] w_gain_raw = word[`WORD_GAIN_LSB +: 4];
  wire [3:0] w_gain = (w_gain_raw > `GAIN_MAX) ? `GAIN_MAX : w_gain_raw;
  wire [15:0] gate_dec = onehot({1'b0, word[2:0]});
  wire [15:0] mod_dec = onehot(word[6:3]);
  wire [15:0] unit_dec = onehot({2'h0, word[8:7]});
  wire take = (state == S_IDLE) && pending && (period_cnt == 13'h0000);
  // slower modes stretch the cycle; autorange wins over suppression
  wire [12:0] period_sel = auto_en ? 13'(AUTO_PERIOD - 1) :
                           zs_en ? 13'(ZS_PERIOD - 1) :
                           13'(STD_PERIOD - 1);
  // below 3/8 of full scale, so doubling the gain cannot overflow
  wire step_up = auto_en & below_s & (gain_o != `GAIN_MAX);

  // result buffering
  wire room = ~valid | rd_res;
  wire load_rd = room & (s2_full | conv_done);
  wire s2_load = conv_done & (s2_full | ~room);
  wire [11:0] src_data = s2_full ? s2_data : conv_data;
  wire [3:0] src_gain = s2_full ? s2_gain : cv_gain;
  wire ser_tick = div_cnt == 8'(SER_DIV - 1);

  sar_engine #(
    .WIDTH(12),
    .BIT_CYC(BIT_CYC)
  ) u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(conv_start),
    .cmp_i(cmp_s),
    .dac_o(dac_o),
    .busy_o(conv_busy),
    .done_o(conv_done),
    .result_o(conv_data)
  );

  always_ff @(posedge clk_i) begin
    cmp_m <= cmp_i;
    cmp_s <= cmp_m;
    below_m <= below_range_i;
    below_s <= below_m;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {zs_en, auto_en} <= `CTRL_RST;
      word <= `WORD_RST;
      offset <= `OFFSET_RST;
      offset_dac_o <= `OFFSET_RST;
      pending <= 1'b0;
      bad_addr <= 1'b0;
    end else begin
      if (wr & hit_ctrl) begin
        auto_en <= m_ctrl[`CTRL_AUTO_BIT];
        zs_en <= m_ctrl[`CTRL_ZS_BIT];
      end
      if (wr & hit_off) begin
        offset <= m_off[14:0];
      end
      offset_dac_o <= zs_en ? offset : `OFFSET_RST;
      if (wr_word & word_ok) begin
        word <= m_word[12:0];
      end
      // a new word in the cycle it is taken keeps the flag set
      pending <= (wr_word & word_ok) | (pending & ~take);
      bad_addr <= (wr_word & ~word_ok) | (bad_addr & ~rd_stat);
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take) begin
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (tmr == 13'h0000 && !step_up) begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!conv_busy) begin
          next_state = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        if (tmr == 13'h0000) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      tmr <= 13'h0000;
      period_cnt <= 13'h0000;
      chan_gate_o <= 8'h00;
      module_en_o <= 16'h0000;
      unit_en_o <= 4'h0;
      gain_o <= 4'h0;
      sample_o <= 1'b0;
      conv_start <= 1'b0;
      cv_gain <= 4'h0;
    end else begin
      state <= next_state;
      conv_start <= 1'b0;
      if (period_cnt != 13'h0000) begin
        period_cnt <= period_cnt - 13'h0001;
      end
      case (state)
        S_IDLE: begin
          // the previous sample may still be converting here
          if (take) begin
            tmr <= 13'(SETTLE_CYC - 1);
            period_cnt <= period_sel;
            chan_gate_o <= gate_dec[7:0];
            module_en_o <= mod_dec;
            unit_en_o <= unit_dec[3:0];
            gain_o <= auto_en ? 4'h0 : w_gain;
          end
        end
        S_SETTLE: begin
          if (tmr != 13'h0000) begin
            tmr <= tmr - 13'h0001;
          end else if (step_up) begin
            gain_o <= gain_o + 4'h1;
            tmr <= 13'(SETTLE_CYC - 1);
          end
        end
        S_WAIT: begin
          // the hold capacitor is busy until the converter lets go
          if (!conv_busy) begin
            sample_o <= 1'b1;
            tmr <= 13'(SAMPLE_CYC - 1);
          end
        end
        S_SAMPLE: begin
          if (tmr != 13'h0000) begin
            tmr <= tmr - 13'h0001;
          end else begin
            sample_o <= 1'b0;
            conv_start <= 1'b1;
            cv_gain <= gain_o;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s2_full <= 1'b0;
      s2_data <= 12'h000;
      s2_gain <= 4'h0;
      valid <= 1'b0;
      res_data <= 12'h000;
      res_gain <= 4'h0;
      overrun <= 1'b0;
    end else begin
      s2_full <= s2_load | (s2_full & ~room);
      if (s2_load) begin
        s2_data <= conv_data;
        s2_gain <= cv_gain;
      end
      valid <= load_rd | (valid & ~rd_res);
      if (load_rd) begin
        res_data <= src_data;
        res_gain <= src_gain;
      end
      overrun <= (conv_done & s2_full & ~room) | (overrun & ~rd_stat);
    end
  end

  // a fresh result restarts the shifter; the slowest frame fits a period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 8'h00;
      sh <= 16'h0000;
      sh_cnt <= 5'h00;
      ser_frame_o <= 1'b0;
      ser_clk_o <= 1'b0;
      ser_data_o <= 1'b0;
    end else begin
      div_cnt <= ser_tick ? 8'h00 : div_cnt + 8'h01;
      if (load_rd) begin
        sh <= {src_gain, src_data};
        sh_cnt <= 5'h10;
        ser_frame_o <= 1'b1;
        ser_clk_o <= 1'b0;
        ser_data_o <= src_gain[3];
      end else if (ser_tick && ser_frame_o) begin
        if (!ser_clk_o) begin
          ser_clk_o <= 1'b1;
        end else begin
          ser_clk_o <= 1'b0;
          sh <= sh << 1;
          ser_data_o <= sh[14];
          sh_cnt <= sh_cnt - 5'h01;
          ser_frame_o <= sh_cnt != 5'h01;
        end
      end
    end
  end

  logic [12:0] gap_cnt;
  logic started;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_cnt <= 13'h0000;
      started <= 1'b0;
    end else begin
      started <= started | take;
      gap_cnt <= take ? 13'h0000 :
                 (gap_cnt == 13'h1FFF) ? gap_cnt : gap_cnt + 13'h0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  word_capture_a: assert property (
    wr_word && word_ok |=> pending && word == $past(m_word[12:0]))
    else $error("address-gain word not captured");
  select_decode_a: assert property (
    take |=> chan_gate_o == $past(gate_dec[7:0])
             && (auto_en || gain_o == $past(w_gain)))
    else $error("gate or gain not set from the word");
  gate_onehot_a: assert property ($onehot0(chan_gate_o))
    else $error("more than one channel gate closed");
  module_onehot_a: assert property (
    seq_busy |-> $onehot(module_en_o))
    else $error("module enable not one-hot");
  gain_limit_a: assert property (gain_o <= `GAIN_MAX)
    else $error("gain beyond 2048");
  range_step_a: assert property (
    state == S_SETTLE && tmr == 13'h0000 && step_up
    |=> gain_o == $past(gain_o) + 4'h1 && state == S_SETTLE)
    else $error("autorange did not step the gain");
  range_stop_a: assert property (
    state == S_SETTLE && tmr == 13'h0000 && !step_up
    |=> state == S_WAIT && $stable(gain_o))
    else $error("autorange did not stop");
  conv_time_a: assert property (
    conv_start |-> ##[1:CONV_CYC] conv_done)
    else $error("conversion longer than 15 us");
  cycle_order_a: assert property (
    $rose(sample_o) |-> $past(state) == S_WAIT ##SAMPLE_CYC conv_start)
    else $error("sample and convert out of order");
  cycle_rate_a: assert property (
    take && started |-> gap_cnt >= 13'(STD_PERIOD - 1))
    else $error("cycle rate too high");
  buffer_load_a: assert property (
    conv_done && !valid && !s2_full |=> valid && res_data == $past(conv_data))
    else $error("result not made readable");
  buffer_hold_a: assert property (
    valid && !rd_res |=> valid && $stable(res_data))
    else $error("unread result overwritten");
  serial_start_a: assert property (
    load_rd |=> ser_frame_o && ser_data_o == $past(src_gain[3]))
    else $error("serial frame did not start");
endmodule

// [analog_front.sv]
`timescale 1ns/10ps
module analog_front (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [3:0] gain_i,
  input wire logic [11:0] dac_i,
  input wire logic signed [15:0] sig_i,
  output logic cmp_o,
  output logic below_o
);
  logic signed [31:0] wide;
  logic signed [31:0] clip;
  logic signed [31:0] held = 0;
  assign wide = 32'(sig_i) <<< gain_i;
  // amplifier saturates at the converter's full scale
  assign clip = wide > 2047 ? 2047 : (wide < -2048 ? -2048 : wide);
  // tracks while sampling, holds otherwise
  // plain always: the initial value keeps cmp_o defined before any sample
  always @(posedge clk_i) begin
    if (sample_i) begin
      held <= clip;
    end
  end
  assign cmp_o = (held + 2048) >= int'(dac_i);
  // below 3/8 of full scale means the gain may double
  assign below_o = (clip < 768) && (clip > -768);
endmodule

// [wide_range_scan_sequencer_tb.sv]
`timescale 1ns/10ps
`include "wr_scan_consts.svh"
module wide_range_scan_sequencer_tb;
  typedef struct {
    logic [8:0] ch;
    logic [3:0] g;
    logic signed [15:0] sig;
    logic [11:0] d;
  } row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cmp_i, below_range_i, sample_o;
  logic ser_data_o, ser_clk_o, ser_frame_o;
  logic [7:0] chan_gate_o;
  logic [15:0] module_en_o;
  logic [3:0] unit_en_o, gain_o;
  logic [11:0] dac_o;
  logic [14:0] offset_dac_o;
  logic signed [15:0] sig = 16'h0000;
  logic [15:0] sh = 16'h0000;
  logic [31:0] q;
  int fail_count = 0;
  int check_count = 0;
  row_type rows [12];
  always #20 clk_i = ~clk_i;
  wide_range_scan_sequencer #(.POP_GROUPS(48), .STD_PERIOD(200),
    .ZS_PERIOD(300), .AUTO_PERIOD(600)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmp_i(cmp_i), .below_range_i(below_range_i),
    .chan_gate_o(chan_gate_o), .module_en_o(module_en_o),
    .unit_en_o(unit_en_o), .gain_o(gain_o), .sample_o(sample_o),
    .dac_o(dac_o), .offset_dac_o(offset_dac_o), .ser_data_o(ser_data_o),
    .ser_clk_o(ser_clk_o), .ser_frame_o(ser_frame_o));
  analog_front i_front (.clk_i(clk_i), .sample_i(sample_o),
    .gain_i(gain_o), .dac_i(dac_o), .sig_i(sig), .cmp_o(cmp_i),
    .below_o(below_range_i));
  always @(posedge ser_clk_o) begin
    if (ser_frame_o === 1'b1) begin
      sh <= {sh[14:0], ser_data_o};
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
      fail_count++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // polls a register until one bit reaches the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v,
                      output logic [31:0] r);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0000_0000, r);
      n++;
    end while (r[b] !== v && n < 400);
    if (n >= 400) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic auto_case(input logic [15:0] s, input logic [31:0] e);
    sig <= s;
    bus(1'b1, `WORD_OFS, 32'h0000_0005, q);
    poll(`RESULT_OFS, 16, 1'b1, q);
    chk(q, e);
  endtask
  initial begin
    rows = '{'{9'h000, 4'h0, 16'h03E8, 12'h3E8},
      '{9'h009, 4'h1, 16'hFED4, 12'hDA8}, '{9'h012, 4'h2, 16'h0064, 12'h190},
      '{9'h01B, 4'h3, 16'hFFCE, 12'hE70}, '{9'h024, 4'h4, 16'h003C, 12'h3C0},
      '{9'h02D, 4'h5, 16'hFFE2, 12'hC40}, '{9'h036, 4'h6, 16'h001F, 12'h7C0},
      '{9'h03F, 4'h7, 16'hFFF0, 12'h800}, '{9'h07F, 4'h8, 16'h0003, 12'h300},
      '{9'h0C8, 4'h9, 16'h0002, 12'h400}, '{9'h12C, 4'hA, 16'hFFFF, 12'hC00},
      '{9'h17F, 4'hB, 16'h0000, 12'h000}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({unit_en_o, module_en_o, chan_gate_o, gain_o}, 32'h0000_0000);
    bus(1'b0, `CTRL_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b0, `OFFSET_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      sig <= rows[i].sig;
      bus(1'b1, `WORD_OFS, 32'({rows[i].g, rows[i].ch}), q);
      poll(`RESULT_OFS, 16, 1'b1, q);
      chk(q, {15'h0000, 1'b1, rows[i].g, rows[i].d});
      chk({unit_en_o, module_en_o, chan_gate_o, gain_o},
          {4'h1 << rows[i].ch[8:7], 16'h0001 << rows[i].ch[6:3],
           8'h01 << rows[i].ch[2:0], rows[i].g});
      while (ser_frame_o !== 1'b0) @(posedge clk_i);
      chk({16'h0000, sh}, {16'h0000, rows[i].g, rows[i].d});
    end
    $display("row test done");
    bus(1'b1, `WORD_OFS, 32'h0000_0390, q);
    bus(1'b0, `STATUS_OFS, 32'h0000_0000, q);
    chk(32'(q[3]), 32'h0000_0001);
    bus(1'b0, `STATUS_OFS, 32'h0000_0000, q);
    chk(32'(q[3]), 32'h0000_0000);
    bus(1'b0, `WORD_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_177F);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h20, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    $display("address test done");
    sig <= 16'h0064;
    bus(1'b1, `WORD_OFS, 32'h0000_0401, q);
    bus(1'b1, `WORD_OFS, 32'h0000_0602, q);
    poll(`STATUS_OFS, 2, 1'b0, q);
    chk(32'(q[1:0]), 32'h0000_0003);
    chk(32'(chan_gate_o), 32'h0000_0004);
    poll(`STATUS_OFS, 0, 1'b0, q);
    poll(`STATUS_OFS, 1, 1'b0, q);
    bus(1'b0, `RESULT_OFS, 32'h0000_0000, q);
    chk(q, 32'h0001_2190);
    bus(1'b0, `RESULT_OFS, 32'h0000_0000, q);
    chk(q, 32'h0001_3320);
    bus(1'b0, `RESULT_OFS, 32'h0000_0000, q);
    chk(32'(q[16]), 32'h0000_0000);
    bus(1'b1, `WORD_OFS, 32'h0000_0401, q);
    poll(`STATUS_OFS, 2, 1'b0, q);
    bus(1'b1, `WORD_OFS, 32'h0000_0602, q);
    poll(`STATUS_OFS, 2, 1'b0, q);
    bus(1'b1, `WORD_OFS, 32'h0000_0803, q);
    poll(`STATUS_OFS, 4, 1'b1, q);
    chk(32'(q[4:3]), 32'h0000_0002);
    bus(1'b0, `STATUS_OFS, 32'h0000_0000, q);
    chk(32'(q[4]), 32'h0000_0000);
    bus(1'b0, `RESULT_OFS, 32'h0000_0000, q);
    chk(q, 32'h0001_2190);
    bus(1'b0, `RESULT_OFS, 32'h0000_0000, q);
    chk(q, 32'h0001_4640);
    $display("buffer test done");
    bus(1'b1, `CTRL_OFS, 32'h0000_0001, q);
    auto_case(16'h0005, 32'h0001_8500);
    auto_case(16'h0300, 32'h0001_0300);
    auto_case(16'h0000, 32'h0001_B000);
    $display("autorange test done");
    bus(1'b1, `CTRL_OFS, 32'h0000_0002, q);
    bus(1'b1, `OFFSET_OFS, 32'h0000_4321, q);
    repeat (2) @(posedge clk_i);
    chk(32'(offset_dac_o), 32'h0000_4321);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(offset_dac_o), 32'h0000_0000);
    bus(1'b0, `CTRL_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    $display("offset test done");
    close_out;
  end
  // the whole run needs roughly 11000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    close_out;
  end
endmodule
